// *** core/host_bridge_pci_arb_ctrl.sv ***
`timescale 1ns/1ps
`include "host_bridge_map.svh"

module host_bridge_pci_arb_ctrl
    import host_bridge_pkg::*;
(
    input  wire logic        mclk,           // System clock
    input  wire logic        rst_b,          // Async reset, active low
    input  wire logic        cfgRead,        // Config read strobe
    input  wire logic        cfgWrite,       // Config write strobe
    input  wire logic [7:0]  cfgAddr,        // Config byte offset
    input  wire logic [3:0]  cfgByteEn,      // Write byte lanes
    input  wire logic [31:0] cfgWdata,       // Write data
    input  wire logic [7:0]  cfgReaderId,    // Bus id of requester
    output logic      [31:0] cfgRdata,       // Read data
    output logic             cfgAck,         // Access done pulse
    input  wire logic        procReadyPin,   // Processor connect request
    input  wire logic        pciTxn,         // PCI/AGP memory transaction
    input  wire logic        probeMatch,     // Matching read probe outstanding
    output logic             memStall,       // Stall memory controller
    input  wire logic        fullBlockWrite, // PCI full-block write pulse
    output logic             rdInvProbe,     // Read-invalidate probe pulse
    output logic             noopInvProbe,   // No-op-invalidate probe pulse
    input  wire logic        memRefValid,    // Memory reference present
    input  wire logic        ioRefValid,     // I/O reference present
    input  wire logic [31:0] refAddr,        // Reference address
    input  wire logic        vgaEnable,      // Bridge VGA enable
    output logic             agpRoute,       // ROM segment to AGP
    output logic             monoToPci,      // Display ref to PCI
    input  wire logic        tgtActive,      // Target cycle in progress
    input  wire logic        tgtIsWrite,     // Target cycle is write
    input  wire logic        tgtIsAgp,       // Target cycle on AGP
    input  wire logic        tgtDataDone,    // Data phase served
    output logic             rdRetry,        // Read latency retry pulse
    output logic             wrRetry,        // Write latency retry pulse
    input  wire logic        pciPostPend,    // PCI posted writes pending
    input  wire logic        agpPostPend,    // AGP posted writes pending
    output logic             pciPostRetry,   // Retry PCI cycle
    output logic             agpPostRetry,   // Retry AGP cycle
    input  wire logic        masterAbort,    // CPU read master-aborted
    input  wire logic        specialCycle,   // Cycle is special
    output logic             rdErr,          // Read data error pulse
    output logic             allOnes,        // All-ones data pulse
    input  wire logic        agpExtWrite,    // AGP master write seen
    input  wire logic        pciExtWrite,    // PCI master write seen
    output logic             agpEarlyProbe,  // Early probe pulse, AGP
    output logic             pciEarlyProbe,  // Early probe pulse, PCI
    input  wire logic        postedBusy,     // Posted requests outstanding
    output logic             sbGrantOk,      // Southbridge may be granted
    input  wire logic        dmaValid,       // External master address valid
    output logic             dmaClaim,       // Decode claims address
    output logic             selfRefresh,    // Self-refresh enable
    output logic             agpChain,       // Chain AGP writes
    output logic             pciChain,       // Chain PCI writes
    output logic             agpPipeOff,     // No pipelined AGP grants
    output logic             agpPrefetch,    // AGP DRAM prefetch
    output logic             pciPrefetch,    // PCI DRAM prefetch
    output logic             parkExternal,   // Park on external master
    output logic             powerRegAccess  // Power register access
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rstS1;
    logic rstSync_b;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstS1     <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstS1     <= 1'b1;
            rstSync_b <= rstS1;
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    state_t st_reg;
    state_t st_next;
    logic [31:0] wMask;
    logic [31:0] ac;
    logic        rdLatOn;
    logic        wrLatOn;
    logic        latOn;
    logic [5:0]  latLimit;
    logic [2:0]  segIdx;
    logic        inRom;
    logic        inMonoMem;
    logic        monoIo;
    logic        in14;
    logic        in15;

    assign wMask = {{8{cfgByteEn[3]}}, {8{cfgByteEn[2]}},
                    {8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};
    assign ac    = st_reg.arbCtl;

    always_comb begin
        st_next = st_reg;
        st_next.procRdyS1 = procReadyPin;
        st_next.procRdyS2 = st_reg.procRdyS1;
        st_next.ack = 1'b0;

        // Register writes; masks keep reserved bits at zero
        if (cfgWrite) begin
            if (cfgAddr == `OFS_MEMORY_CTRL_STATUS) begin
                if (cfgByteEn[2]) st_next.selfRefresh = cfgWdata[`MC_SELF_REFRESH_BIT];
                if (cfgByteEn[1]) st_next.pciPipe = cfgWdata[`MC_PCI_PIPE_BIT];
                if (cfgByteEn[1]) st_next.blockWrite = cfgWdata[`MC_BLOCK_WRITE_BIT];
            end else if (cfgAddr == `OFS_PCI_ARBITER_CONTROL) begin
                st_next.arbCtl = (ac & ~(wMask & `AC_WRITE_MASK))
                               | (cfgWdata & wMask & `AC_WRITE_MASK);
            end
            st_next.ack = 1'b1;
        end

        // Register reads; unmapped offsets read zero
        if (cfgRead) begin
            st_next.ack   = 1'b1;
            st_next.rdata = 32'h0000_0000;
            case (cfgAddr)
                `OFS_MEMORY_CTRL_STATUS: begin
                    st_next.rdata[`MC_SELF_REFRESH_BIT] = st_reg.selfRefresh;
                    st_next.rdata[`MC_PCI_PIPE_BIT]     = st_reg.pciPipe;
                    st_next.rdata[`MC_BLOCK_WRITE_BIT]  = st_reg.blockWrite;
                end
                `OFS_PROCESSOR_IDENTITY: begin
                    st_next.rdata[`ID_PRESENT_BIT] = st_reg.procRdyS2;
                    st_next.rdata[7:0] = cfgReaderId;
                    if (st_reg.firstSeen) begin
                        st_next.rdata[`ID_FIRST_MSB:`ID_FIRST_LSB] = st_reg.firstId;
                    end else begin
                        // The first reader sees its own id in both bytes
                        st_next.rdata[`ID_FIRST_MSB:`ID_FIRST_LSB] = cfgReaderId;
                        st_next.firstId   = cfgReaderId;
                        st_next.firstSeen = 1'b1;
                    end
                end
                `OFS_PCI_ARBITER_CONTROL: begin
                    st_next.rdata = ac & `AC_WRITE_MASK;
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Memory controller ordering
        st_next.memStall     = pciTxn & probeMatch & ~st_reg.pciPipe;
        st_next.rdInvProbe   = fullBlockWrite & ~st_reg.blockWrite;
        st_next.noopInvProbe = fullBlockWrite & st_reg.blockWrite;

        // Legacy display decode
        inRom  = memRefValid && refAddr >= `VGA_ROM_BASE && refAddr <= `VGA_ROM_END;
        segIdx = 3'(refAddr[`VGA_SEG_SHIFT +: 3]);
        st_next.agpRoute = inRom & ac[`AC_VGA_LSB + 32'(segIdx)];
        inMonoMem = memRefValid && refAddr >= `MONO_MEM_BASE && refAddr <= `MONO_MEM_END;
        monoIo = ioRefValid && (refAddr[15:0] == 16'h03B4 || refAddr[15:0] == 16'h03B5 ||
                 refAddr[15:0] == 16'h03B8 || refAddr[15:0] == 16'h03B9 ||
                 refAddr[15:0] == 16'h03BA || refAddr[15:0] == `MONO_IO_DEBUG);
        if (!vgaEnable) begin
            // VGA off with debug on is undefined; route to PCI as well
            st_next.monoToPci = memRefValid | ioRefValid;
        end else if (!ac[`AC_MONO_DEBUG]) begin
            st_next.monoToPci = ioRefValid && refAddr[15:0] == `MONO_IO_DEBUG;
        end else begin
            st_next.monoToPci = inMonoMem | monoIo;
        end

        // Target latency timer
        rdLatOn  = ac[`AC_TGT_LATENCY] & ~ac[`AC_TIMER_OFF] & ~tgtIsAgp;
        wrLatOn  = ~ac[`AC_TIMER_OFF];
        latOn    = tgtIsWrite ? wrLatOn : rdLatOn;
        latLimit = !st_reg.latFirst ? `NEXT_LIMIT :
                   (tgtIsWrite ? `WR_FIRST_LIMIT : `RD_FIRST_LIMIT);
        st_next.rdRetry = 1'b0;
        st_next.wrRetry = 1'b0;
        if (!tgtActive) begin
            st_next.latCnt   = 6'h00;
            st_next.latFirst = 1'b1;
        end else if (tgtDataDone) begin
            st_next.latCnt   = 6'h00;
            st_next.latFirst = 1'b0;
        end else if (latOn && st_reg.latCnt == latLimit - 6'h01) begin
            st_next.latCnt   = 6'h00;
            st_next.latFirst = 1'b1;
            st_next.rdRetry  = ~tgtIsWrite;
            st_next.wrRetry  = tgtIsWrite;
        end else if (latOn) begin
            st_next.latCnt = st_reg.latCnt + 6'h01;
        end

        st_next.pciPostRetry = ac[`AC_PCI_POST_RETRY] & pciPostPend;
        st_next.agpPostRetry = ac[`AC_AGP_POST_RETRY] & agpPostPend;

        st_next.rdErr   = masterAbort & ~specialCycle & ~ac[`AC_RD_ERR_OFF];
        st_next.allOnes = masterAbort & ~specialCycle & ac[`AC_RD_ERR_OFF];

        st_next.agpEarlyProbe = agpExtWrite & ~ac[`AC_AGP_EARLY_OFF];
        st_next.pciEarlyProbe = pciExtWrite & ~ac[`AC_PCI_EARLY_OFF];

        st_next.sbGrantOk = ac[`AC_SB_FLUSH_OFF] | ~postedBusy;

        // External master decode; flat mode ignores both holes
        in14 = refAddr >= `HOLE_14M_BASE && refAddr < `HOLE_15M_BASE;
        in15 = refAddr >= `HOLE_15M_BASE && refAddr < `HOLE_16M_BASE;
        st_next.dmaClaim = dmaValid & (ac[`AC_FLAT_DECODE] |
                           ~((ac[`AC_HOLE_14M] & in14) | (ac[`AC_HOLE_15M] & in15)));
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            st_reg        <= '0;
            st_reg.arbCtl <= `AC_RESET;
            // Self refresh has no defined value; zero is the safe choice
            st_reg.selfRefresh <= 1'b0;
            st_reg.sbGrantOk   <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cfgRdata       = st_reg.rdata;
    assign cfgAck         = st_reg.ack;
    assign memStall       = st_reg.memStall;
    assign rdInvProbe     = st_reg.rdInvProbe;
    assign noopInvProbe   = st_reg.noopInvProbe;
    assign agpRoute       = st_reg.agpRoute;
    assign monoToPci      = st_reg.monoToPci;
    assign rdRetry        = st_reg.rdRetry;
    assign wrRetry        = st_reg.wrRetry;
    assign pciPostRetry   = st_reg.pciPostRetry;
    assign agpPostRetry   = st_reg.agpPostRetry;
    assign rdErr          = st_reg.rdErr;
    assign allOnes        = st_reg.allOnes;
    assign agpEarlyProbe  = st_reg.agpEarlyProbe;
    assign pciEarlyProbe  = st_reg.pciEarlyProbe;
    assign sbGrantOk      = st_reg.sbGrantOk;
    assign dmaClaim       = st_reg.dmaClaim;
    assign selfRefresh    = st_reg.selfRefresh;
    assign agpChain       = ac[`AC_AGP_CHAIN];
    assign pciChain       = ac[`AC_PCI_CHAIN];
    assign agpPipeOff     = ac[`AC_AGP_PIPE_OFF];
    assign agpPrefetch    = ac[`AC_AGP_PREFETCH];
    assign pciPrefetch    = ac[`AC_PCI_PREFETCH];
    assign parkExternal   = ac[`AC_PARK_PCI];
    assign powerRegAccess = ac[`AC_POWER_REG];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_PIPE_STALL: assert property (@(posedge mclk) disable iff (!rstSync_b)
        pciTxn && probeMatch && !st_reg.pciPipe && !cfgWrite |=> memStall)
        else $error("stall missing while pipelining off");
    AST_PROBE_KIND: assert property (@(posedge mclk) disable iff (!rstSync_b)
        fullBlockWrite && !cfgWrite |=> (rdInvProbe != noopInvProbe)
            && (noopInvProbe == $past(st_reg.blockWrite)))
        else $error("wrong probe kind for block write");
    AST_PRESENT: assert property (@(posedge mclk) disable iff (!rstSync_b)
        cfgRead && cfgAddr == `OFS_PROCESSOR_IDENTITY |=>
            cfgRdata[`ID_PRESENT_BIT] == $past(procReadyPin, 3))
        else $error("present bit does not follow ready");
    AST_FIRST_ID: assert property (@(posedge mclk) disable iff (!rstSync_b)
        st_reg.firstSeen && cfgRead && cfgAddr == `OFS_PROCESSOR_IDENTITY |=>
            cfgRdata[15:8] == st_reg.firstId && st_reg.firstSeen)
        else $error("first reader id changed");
    AST_READER_ID: assert property (@(posedge mclk) disable iff (!rstSync_b)
        cfgRead && cfgAddr == `OFS_PROCESSOR_IDENTITY |=>
            cfgAck && cfgRdata[7:0] == $past(cfgReaderId))
        else $error("identity low byte wrong");
    AST_RD_RETRY: assert property (@(posedge mclk) disable iff (!rstSync_b)
        rdRetry |-> $past(st_reg.arbCtl[`AC_TGT_LATENCY]) && !$past(tgtIsAgp)
            && !$past(st_reg.arbCtl[`AC_TIMER_OFF]))
        else $error("read retry while disabled");
    AST_WR_FIRST: assert property (@(posedge mclk) disable iff (!rstSync_b)
        $rose(tgtActive) && tgtIsWrite && !ac[`AC_TIMER_OFF] && !cfgWrite
        ##1 (tgtActive && tgtIsWrite && !tgtDataDone && !cfgWrite)[*8]
        ##1 (tgtActive && tgtIsWrite && !tgtDataDone && !cfgWrite)[*7]
        |=> wrRetry)
        else $error("write retry not at 16 clocks");
    AST_ABORT: assert property (@(posedge mclk) disable iff (!rstSync_b)
        masterAbort && !specialCycle && !cfgWrite |=> rdErr ^ allOnes)
        else $error("master abort gives no answer");
    AST_SB_FLUSH: assert property (@(posedge mclk) disable iff (!rstSync_b)
        postedBusy && !ac[`AC_SB_FLUSH_OFF] && !cfgWrite |=> !sbGrantOk)
        else $error("grant allowed before flush");
    AST_RESERVED: assert property (@(posedge mclk) disable iff (!rstSync_b)
        cfgRead && cfgAddr == `OFS_PCI_ARBITER_CONTROL |=> cfgRdata[22:18] == 5'h00)
        else $error("reserved bits not zero");
    AST_ROM_LOW: assert property (@(posedge mclk) disable iff (!rstSync_b)
        memRefValid && refAddr >= `VGA_ROM_BASE && refAddr <= `VGA_SEG_FIRST_END
            |=> agpRoute == $past(ac[`AC_VGA_LSB]))
        else $error("lowest rom segment routed wrong");
    AST_ROM_HIGH: assert property (@(posedge mclk) disable iff (!rstSync_b)
        memRefValid && refAddr >= `VGA_SEG_LAST_BASE && refAddr <= `VGA_ROM_END
            |=> agpRoute == $past(ac[`AC_VGA_MSB]))
        else $error("highest rom segment routed wrong");
    AST_MONO_IO_ONLY: assert property (@(posedge mclk) disable iff (!rstSync_b)
        vgaEnable && !ac[`AC_MONO_DEBUG] && !(ioRefValid && refAddr[15:0] == `MONO_IO_DEBUG)
            |=> !monoToPci)
        else $error("display reference sent to pci without debug");
    AST_MONO_ALL: assert property (@(posedge mclk) disable iff (!rstSync_b)
        !vgaEnable && (memRefValid || ioRefValid) |=> monoToPci)
        else $error("display reference kept off pci with vga off");
    AST_PCI_POST: assert property (@(posedge mclk) disable iff (!rstSync_b)
        pciPostPend && ac[`AC_PCI_POST_RETRY] |=> pciPostRetry)
        else $error("pci posted write retry missing");
    AST_AGP_POST: assert property (@(posedge mclk) disable iff (!rstSync_b)
        agpPostPend && !ac[`AC_AGP_POST_RETRY] |=> !agpPostRetry)
        else $error("agp retry while posted retry off");
    AST_AGP_EARLY: assert property (@(posedge mclk) disable iff (!rstSync_b)
        agpExtWrite && !ac[`AC_AGP_EARLY_OFF] |=> agpEarlyProbe)
        else $error("agp early probe missing");
    AST_PCI_EARLY_OFF: assert property (@(posedge mclk) disable iff (!rstSync_b)
        pciExtWrite && ac[`AC_PCI_EARLY_OFF] |=> !pciEarlyProbe)
        else $error("pci early probe while disabled");
    AST_HOLE_15M: assert property (@(posedge mclk) disable iff (!rstSync_b)
        dmaValid && ac[`AC_HOLE_15M] && !ac[`AC_FLAT_DECODE] && refAddr >= `HOLE_15M_BASE
            && refAddr < `HOLE_16M_BASE |=> !dmaClaim)
        else $error("address claimed inside hole");
    AST_FLAT_DECODE: assert property (@(posedge mclk) disable iff (!rstSync_b)
        dmaValid && ac[`AC_FLAT_DECODE] |=> dmaClaim)
        else $error("flat decode refused an address");

endmodule

// *** include/host_bridge_map.svh ***
`ifndef HOST_BRIDGE_MAP_SVH
`define HOST_BRIDGE_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets in configuration space
// ----------------------------------------------------------------------
`define OFS_MEMORY_CTRL_STATUS   8'h70
`define OFS_PROCESSOR_IDENTITY   8'h80
`define OFS_PCI_ARBITER_CONTROL  8'h84

// ----------------------------------------------------------------------
// Memory control fields
// ----------------------------------------------------------------------
`define MC_SELF_REFRESH_BIT      18
`define MC_PCI_PIPE_BIT          10
`define MC_BLOCK_WRITE_BIT       9
`define MC_WRITE_MASK            32'h0004_0600

// ----------------------------------------------------------------------
// Identity fields
// ----------------------------------------------------------------------
`define ID_PRESENT_BIT           16
`define ID_FIRST_MSB             15
`define ID_FIRST_LSB             8
`define ID_CPU0                  8'h00
`define ID_CPU1                  8'h01

// ----------------------------------------------------------------------
// Arbiter control fields
// ----------------------------------------------------------------------
`define AC_RESET                 32'h0000_0000
`define AC_WRITE_MASK            32'hFF83_FFFF
`define AC_VGA_MSB               31
`define AC_VGA_LSB               24
`define AC_TGT_LATENCY           23
`define AC_AGP_CHAIN             17
`define AC_PCI_CHAIN             16
`define AC_MONO_DEBUG            15
`define AC_PCI_POST_RETRY        14
`define AC_AGP_POST_RETRY        13
`define AC_RD_ERR_OFF            12
`define AC_AGP_EARLY_OFF         11
`define AC_PCI_EARLY_OFF         10
`define AC_AGP_PIPE_OFF          9
`define AC_SB_FLUSH_OFF          8
`define AC_POWER_REG             7
`define AC_HOLE_15M              6
`define AC_HOLE_14M              5
`define AC_FLAT_DECODE           4
`define AC_TIMER_OFF             3
`define AC_AGP_PREFETCH          2
`define AC_PCI_PREFETCH          1
`define AC_PARK_PCI              0

// ----------------------------------------------------------------------
// Address windows
// ----------------------------------------------------------------------
`define VGA_ROM_BASE             32'h000C_0000
`define VGA_ROM_END              32'h000D_FFFF
`define VGA_SEG_SHIFT            14
`define VGA_SEG_FIRST_END        32'h000C_3FFF
`define VGA_SEG_LAST_BASE        32'h000D_C000
`define MONO_MEM_BASE            32'h000B_0000
`define MONO_MEM_END             32'h000B_7FFF
`define MONO_IO_DEBUG            16'h03BF
`define HOLE_14M_BASE            32'h00E0_0000
`define HOLE_15M_BASE            32'h00F0_0000
`define HOLE_16M_BASE            32'h0100_0000

// ----------------------------------------------------------------------
// Target latency limits in bus clocks
// ----------------------------------------------------------------------
`define RD_FIRST_LIMIT           6'd32
`define WR_FIRST_LIMIT           6'd16
`define NEXT_LIMIT               6'd8

`endif

// *** include/host_bridge_pkg.sv ***
package host_bridge_pkg;

    typedef struct packed {
        logic        procRdyS1;
        logic        procRdyS2;
        logic        selfRefresh;
        logic        pciPipe;
        logic        blockWrite;
        logic [31:0] arbCtl;
        logic        firstSeen;
        logic [7:0]  firstId;
        logic [31:0] rdata;
        logic        ack;
        logic [5:0]  latCnt;
        logic        latFirst;
        logic        rdRetry;
        logic        wrRetry;
        logic        memStall;
        logic        rdInvProbe;
        logic        noopInvProbe;
        logic        agpRoute;
        logic        monoToPci;
        logic        pciPostRetry;
        logic        agpPostRetry;
        logic        rdErr;
        logic        allOnes;
        logic        agpEarlyProbe;
        logic        pciEarlyProbe;
        logic        sbGrantOk;
        logic        dmaClaim;
    } state_t;

endpackage

// *** bench/host_bridge_pci_arb_ctrl_bench.sv ***
`timescale 1ns/1ps
module host_bridge_pci_arb_ctrl_bench;
    logic        mclk, rst_b, cfgRead, cfgWrite, cfgAck, procReadyPin, pciTxn, probeMatch;
    logic        fullBlockWrite, memRefValid, ioRefValid, vgaEnable, tgtActive, tgtIsWrite;
    logic        tgtIsAgp, tgtDataDone, pciPostPend, agpPostPend, masterAbort, specialCycle;
    logic        agpExtWrite, pciExtWrite, postedBusy, dmaValid, memStall, rdInvProbe;
    logic        noopInvProbe, agpRoute, monoToPci, rdRetry, wrRetry, pciPostRetry, rdErr;
    logic        agpPostRetry, allOnes, agpEarlyProbe, pciEarlyProbe, sbGrantOk, dmaClaim;
    logic        selfRefresh, agpChain, pciChain, agpPipeOff, agpPrefetch, pciPrefetch;
    logic        parkExternal, powerRegAccess;
    logic [1:0]  rr;
    logic [3:0]  cfgByteEn;
    logic [7:0]  cfgAddr, cfgReaderId;
    logic [12:0] mk;
    logic [13:0] stim;
    logic [31:0] cfgWdata, cfgRdata, refAddr;
    int          err_total, comparisons, n;

    assign {vgaEnable, pciTxn, probeMatch, fullBlockWrite, memRefValid, ioRefValid, pciPostPend,
            agpPostPend, masterAbort, specialCycle, agpExtWrite, pciExtWrite, postedBusy,
            dmaValid} = stim;
    wire [12:0] ov = {memStall, rdInvProbe, noopInvProbe, agpRoute, monoToPci, pciPostRetry,
                      agpPostRetry, allOnes, rdErr, agpEarlyProbe, pciEarlyProbe, sbGrantOk,
                      dmaClaim};
    wire [6:0]  lv = {agpChain, pciChain, agpPipeOff, agpPrefetch, pciPrefetch, parkExternal,
                      powerRegAccess};

    host_bridge_pci_arb_ctrl host_bridge_pci_arb_ctrl_inst (.*);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Whole run needs well under this many cycles
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        end_sim();
    end

    // --------------------------------------------------------
    // Helpers and scenarios
    // --------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d, input logic [7:0] id, input logic [31:0] e);
        @(posedge mclk);
        {cfgWrite, cfgRead, cfgAddr, cfgByteEn, cfgWdata, cfgReaderId} <= {w, !w, a, be, d, id};
        @(posedge mclk);
        {cfgWrite, cfgRead} <= 2'b00;
        #1;
        chk("cfgAck", cfgAck, 1'b1);
        if (!w) chk("cfgRdata", cfgRdata, e);
    endtask

    // Decode outputs are registered, so look one edge after the inputs
    task automatic dec(input logic [7:0] ra, input logic [31:0] r, input logic [13:0] s,
                       input logic [31:0] a, input logic [12:0] e);
        acc(1'b1, ra, 4'hF, r, 8'h00, 32'h0);
        @(posedge mclk);
        {stim, refAddr} <= {s, a};
        @(posedge mclk);
        stim <= '0;
        #1;
        chk("decode", ov & mk, e);
    endtask

    // Window of three edges: the retry pulse may lag the limit by a flop
    task automatic lat(input logic w, agp, input int dn, input logic [2:0] e, input int lo);
        @(posedge mclk);
        {tgtActive, tgtIsWrite, tgtIsAgp} <= {1'b1, w, agp};
        for (n = 1; n < 40; n++) begin
            @(posedge mclk);
            tgtDataDone <= (n == dn);
            @(negedge mclk);
            rr = {rdRetry, wrRetry};
            if (rr !== 2'b00) break;
        end
        @(posedge mclk);
        {tgtActive, tgtDataDone} <= 2'b00;
        repeat (2) @(posedge mclk);
        chk("latency", {n >= lo && n <= lo + 2, rr}, e);
    endtask

    task automatic end_sim;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic regs;
        acc(1'b0, 8'h84, 4'hF, 32'h0, 8'h00, 32'h0);
        acc(1'b1, 8'h84, 4'hF, 32'hFFFFFFFF, 8'h00, 32'h0);
        acc(1'b0, 8'h84, 4'hF, 32'h0, 8'h00, 32'hFF83FFFF);
        chk("levels", lv, 7'h7F);
        acc(1'b1, 8'h84, 4'h1, 32'h0, 8'h00, 32'h0);
        acc(1'b0, 8'h84, 4'hF, 32'h0, 8'h00, 32'hFF83FF00);
        chk("levels", lv, 7'h70);
        acc(1'b1, 8'h70, 4'hF, 32'hFFFFFFFF, 8'h00, 32'h0);
        acc(1'b0, 8'h70, 4'hF, 32'h0, 8'h00, 32'h40600);
        chk("selfRefresh", selfRefresh, 1'b1);
        acc(1'b0, 8'h90, 4'hF, 32'h0, 8'h00, 32'h0);
        acc(1'b1, 8'h80, 4'hF, 32'hFFFFFFFF, 8'h00, 32'h0);
        acc(1'b0, 8'h80, 4'hF, 32'h0, 8'h01, 32'h10101);
        acc(1'b0, 8'h80, 4'hF, 32'h0, 8'h00, 32'h10100);
    endtask

    task automatic rom_map;
        mk = 13'h200;
        for (int i = 0; i < 8; i++) begin
            dec(8'h84, 32'h100_0000 << i, 14'h200, 32'hC0000 + i * 32'h4000, 13'h200);
            dec(8'h84, 32'h100_0000 << i, 14'h200, 32'hC3FFF + (i + 1) % 8 * 32'h4000, 13'h0);
        end
    endtask

    task automatic decode;
        mk = 13'h1C00;
        dec(8'h70, 32'h0, 14'h1C00, 32'h0, 13'h1800);
        dec(8'h70, 32'h600, 14'h1C00, 32'h0, 13'h0400);
        mk = 13'h100;
        dec(8'h84, 32'h0, 14'h2100, 32'h3BF, 13'h100);
        dec(8'h84, 32'h0, 14'h2100, 32'h3B4, 13'h0);
        dec(8'h84, 32'h0, 14'h2200, 32'hB0000, 13'h0);
        dec(8'h84, 32'h8000, 14'h2200, 32'hB7FFF, 13'h100);
        dec(8'h84, 32'h8000, 14'h2100, 32'h3B4, 13'h100);
        dec(8'h84, 32'h0, 14'h0200, 32'hB0000, 13'h100);
        mk = 13'hFF;
        dec(8'h84, 32'h0, 14'hEF, 32'hF00000, 13'h1D);
        dec(8'h84, 32'h7D40, 14'hEF, 32'hF00000, 13'hE2);
        dec(8'h84, 32'h70, 14'hFF, 32'hE00000, 13'h0D);
        dec(8'h84, 32'h20, 14'hEF, 32'hE80000, 13'h1C);
        dec(8'h84, 32'h40, 14'hEF, 32'h1000000, 13'h1D);
    endtask

    task automatic latency;
        acc(1'b1, 8'h84, 4'hF, 32'h800000, 8'h00, 32'h0);
        lat(1'b0, 1'b0, 0, 3'b110, 32);
        lat(1'b0, 1'b0, 4, 3'b110, 12);
        lat(1'b1, 1'b0, 0, 3'b101, 16);
        lat(1'b0, 1'b1, 0, 3'b100, 40);
        acc(1'b1, 8'h84, 4'hF, 32'h800008, 8'h00, 32'h0);
        lat(1'b0, 1'b0, 0, 3'b100, 40);
        lat(1'b1, 1'b1, 0, 3'b100, 40);
        acc(1'b1, 8'h84, 4'hF, 32'h0, 8'h00, 32'h0);
        lat(1'b0, 1'b0, 0, 3'b100, 40);
        lat(1'b1, 1'b1, 0, 3'b101, 16);
    endtask

    initial begin
        {rst_b, cfgRead, cfgWrite, procReadyPin, tgtActive, tgtIsWrite, tgtIsAgp} = '0;
        {tgtDataDone, stim, mk, cfgAddr, cfgReaderId, cfgByteEn, cfgWdata, refAddr} = '0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        procReadyPin <= 1'b1;
        repeat (6) @(posedge mclk);
        regs();
        rom_map();
        decode();
        latency();
        end_sim();
    end
endmodule
